// File: design/pxb_defs.vh
// What this block does
// (RULE1) Each selected function gets own pin, fixed priority
// (RULE2) Only unskipped pins P0.0 to P1.6 assignable
// (RULE3) Async serial port always takes P0.4, P0.5
// (RULE4) Second serial peripheral always takes P1.0 to P1.3
// (RULE5) Others take lowest free pins, by priority
// (RULE6) Skip pins already assigned or skip-masked
// (RULE7) Software keeps fixed pins unskipped when selected
// (RULE8) Software skips analog, GPIO, dedicated pins
// (RULE9) Drivers off while crossbar enable is zero
// (RULE10) Two-wire bus pins forced open-drain
// (RULE11) Slave-select routed only in 4-wire mode
// (RULE12) First serial mode shifts lower-priority pinout
// (RULE13) Port 1 data: latch write, pin read
// (RULE14) Port 1 skip bit one excludes pin
// (RULE15) Software skips crystal pins with 0x0C
// (RULE16) Routing follows current settings, no commit
`ifndef PXB_DEFS_VH
`define PXB_DEFS_VH

`define PXB_NPIN        15
`define PXB_NSLOT       24
`define PXB_SLOT_W      5
`define PXB_DYN_FIRST   6
`define PXB_SLOT_FIRST_SERIAL_PERIPHERAL   6
`define PXB_SLOT_NSS    9
`define PXB_SLOT_SDA    10
`define PXB_SLOT_SCL    11
`define PXB_SLOT_CP0    12
`define PXB_SLOT_CP1    13
`define PXB_SLOT_SYSCLK 14
`define PXB_SLOT_CEX0   15
`define PXB_NCEX        6
`define PXB_SLOT_ECI    21
`define PXB_SLOT_T0     22
`define PXB_SLOT_T1     23
`define PXB_SLOT_UART_TX 5'h00
`define PXB_SLOT_UART_RX 5'h01
`define PXB_SLOT_SECOND_SERIAL_PERIPHERAL   2
`define PXB_NSPI1       4

`define PXB_PIN_UART_TX 4
`define PXB_PIN_UART_RX 5
`define PXB_PIN_SECOND_SERIAL_PERIPHERAL_LO 8

`define PXB_ADDR_P1     8'h90
`define PXB_ADDR_P1SK   8'hd5
`define PXB_P1_RST      7'h7f
`define PXB_P1SK_RST    7'h00
`define PXB_NSS_3WIRE   2'h0

`endif

// File: design/pxb_priority_pin_crossbar.v
`timescale 1ns/1ps
`include "pxb_defs.vh"

module pxb_priority_pin_crossbar
(
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_rd_i,
  output wire [7:0]  sfr_rdata_o,
  input  wire        crossbar_enable_bit_i,
  input  wire        sel_uart_i,
  input  wire        sel_second_serial_peripheral_i,
  input  wire        sel_first_serial_peripheral_i,
  input  wire        sel_smb_i,
  input  wire        sel_cp0_i,
  input  wire        sel_cp1_i,
  input  wire        sel_sysclk_i,
  input  wire [2:0]  sel_cex_cnt_i,
  input  wire        sel_eci_i,
  input  wire        sel_t0_i,
  input  wire        sel_t1_i,
  input  wire [1:0]  slave_select_mode_field_i,
  input  wire [7:0]  port0_skip_mask_i,
  input  wire [7:0]  port0_latch_i,
  input  wire [14:0] port_output_mode_i,
  input  wire [23:0] periph_out_i,
  input  wire [23:0] periph_drive_i,
  output wire [23:0] periph_in_o,
  input  wire [14:0] pin_in_i,
  output wire [14:0] pin_out_o,
  output wire [14:0] pin_oe_n_o
);

  reg  [6:0]  p1_latch_q;
  reg  [6:0]  p1_skip_q;
  reg  [7:0]  rdata_q;
  reg  [14:0] pin_meta_q;
  reg  [14:0] pin_sync_q;
  reg  [74:0] asg_slot_q;
  reg  [14:0] asg_vld_q;
  wire [74:0] asg_slot_d;
  wire [14:0] asg_vld_d;
  reg  [14:0] pin_out_q;
  reg  [14:0] pin_oe_n_q;
  wire [14:0] pin_out_d;
  wire [14:0] pin_oe_n_d;
  reg  [23:0] periph_in_q;
  wire [23:0] periph_in_d;
  wire [14:0] gpio_latch;
  wire [23:0] slot_en;
  wire [14:0] fixed_mask;
  wire [14:0] skip_mask;
  wire [14:0] free_mask;
  wire        first_serial_peripheral_four_wire;

  assign sfr_rdata_o = rdata_q;
  assign pin_out_o   = pin_out_q;
  assign pin_oe_n_o  = pin_oe_n_q;
  assign periph_in_o = periph_in_q;

  // Pins come from outside; two stages before use
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_meta_q <= 15'h0000;
      pin_sync_q <= 15'h0000;
    end
    else
    begin
      pin_meta_q <= pin_in_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // (RULE13) Port 1 data register
  // (RULE14) Port 1 skip register
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p1_latch_q <= `PXB_P1_RST;
      p1_skip_q  <= `PXB_P1SK_RST;
    end
    else
    begin
      // Bit 7 has no storage; writes to it are dropped
      if (sfr_wr_i && sfr_addr_i == `PXB_ADDR_P1)
        p1_latch_q <= sfr_wdata_i[6:0];
      if (sfr_wr_i && sfr_addr_i == `PXB_ADDR_P1SK)
        p1_skip_q <= sfr_wdata_i[6:0];
    end
  end

  // (RULE13) Read pin state, top bit zero
  // Pin state, not latch: open-drain highs show the wire
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 8'h00;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        `PXB_ADDR_P1:
          rdata_q <= {1'b0, pin_sync_q[14:8]};
        `PXB_ADDR_P1SK:
          rdata_q <= {1'b0, p1_skip_q};
        default:
          rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  // (RULE11) Slave-select only in 4-wire mode
  // Any nonzero mode field counts as 4-wire
  assign first_serial_peripheral_four_wire = (slave_select_mode_field_i != `PXB_NSS_3WIRE);

  // (RULE1) Slots listed in priority order
  assign slot_en[1:0]   = {2{sel_uart_i}};
  assign slot_en[5:2]   = {4{sel_second_serial_peripheral_i}};
  assign slot_en[8:6]   = {3{sel_first_serial_peripheral_i}};
  // (RULE12) Fourth pin consumed only in 4-wire
  assign slot_en[`PXB_SLOT_NSS]    = sel_first_serial_peripheral_i & first_serial_peripheral_four_wire;
  assign slot_en[`PXB_SLOT_SDA]    = sel_smb_i;
  assign slot_en[`PXB_SLOT_SCL]    = sel_smb_i;
  assign slot_en[`PXB_SLOT_CP0]    = sel_cp0_i;
  assign slot_en[`PXB_SLOT_CP1]    = sel_cp1_i;
  assign slot_en[`PXB_SLOT_SYSCLK] = sel_sysclk_i;
  assign slot_en[`PXB_SLOT_ECI]    = sel_eci_i;
  assign slot_en[`PXB_SLOT_T0]     = sel_t0_i;
  assign slot_en[`PXB_SLOT_T1]     = sel_t1_i;

  genvar c;
  generate
    for (c = 0; c < `PXB_NCEX; c = c + 1)
    begin : g_cex
      // Capture channels fill in order, first N only
      assign slot_en[`PXB_SLOT_CEX0 + c] = (sel_cex_cnt_i > c);
    end
  endgenerate

  // (RULE3) Async serial pins reserved
  // (RULE4) Second serial pins reserved
  assign fixed_mask = {3'h0, {4{sel_second_serial_peripheral_i}}, 2'h0, {2{sel_uart_i}}, 4'h0};
  // (RULE2) Pool is P0.0..P1.6 minus skipped
  assign skip_mask  = {p1_skip_q, port0_skip_mask_i};
  assign free_mask  = ~skip_mask & ~fixed_mask;

  // (RULE16) Recomputed every cycle from live settings
  genvar p;
  generate
    for (p = 0; p < `PXB_NPIN; p = p + 1)
    begin : g_pin
      integer   k;
      integer   rank;
      integer   ord;
      integer   sp;
      reg [4:0] slot_d;
      reg       vld_d;

      always @*
      begin
        rank   = 0;
        ord    = 0;
        sp     = p - `PXB_PIN_SECOND_SERIAL_PERIPHERAL_LO + `PXB_SLOT_SECOND_SERIAL_PERIPHERAL;
        slot_d = 5'h00;
        vld_d  = 1'b0;
        // (RULE6) Count only free pins below
        for (k = 0; k < p; k = k + 1)
          if (free_mask[k])
            rank = rank + 1;
        // (RULE5) Nth free pin to Nth enabled slot
        for (k = `PXB_DYN_FIRST; k < `PXB_NSLOT; k = k + 1)
        begin
          if (slot_en[k])
          begin
            if (free_mask[p] && ord == rank)
            begin
              slot_d = k[4:0];
              vld_d  = 1'b1;
            end
            ord = ord + 1;
          end
        end
        // Fixed pins override skip bits; software keeps them clear
        // (RULE3) Fixed pins for async serial
        if (sel_uart_i && p == `PXB_PIN_UART_TX)
        begin
          slot_d = `PXB_SLOT_UART_TX;
          vld_d  = 1'b1;
        end
        if (sel_uart_i && p == `PXB_PIN_UART_RX)
        begin
          slot_d = `PXB_SLOT_UART_RX;
          vld_d  = 1'b1;
        end
        // (RULE4) Fixed pins for second serial
        if (sel_second_serial_peripheral_i && p >= `PXB_PIN_SECOND_SERIAL_PERIPHERAL_LO && p < `PXB_PIN_SECOND_SERIAL_PERIPHERAL_LO + `PXB_NSPI1)
        begin
          slot_d = sp[4:0];
          vld_d  = 1'b1;
        end
      end

      assign asg_slot_d[p*`PXB_SLOT_W +: `PXB_SLOT_W] = slot_d;
      assign asg_vld_d[p] = vld_d;
    end
  endgenerate

  // Routing registered to cut the long search path
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      asg_slot_q <= 75'h0;
      asg_vld_q  <= 15'h0000;
    end
    else
    begin
      asg_slot_q <= asg_slot_d;
      asg_vld_q  <= asg_vld_d;
    end
  end

  // Unrouted pins fall back to the port latches
  assign gpio_latch = {p1_latch_q, port0_latch_i};

  // Pin drivers from registered routing
  genvar d;
  generate
    for (d = 0; d < `PXB_NPIN; d = d + 1)
    begin : g_drv
      wire [4:0] slot;
      reg        val;
      reg        want;
      reg        od;

      assign slot = asg_slot_q[d*`PXB_SLOT_W +: `PXB_SLOT_W];
      always @*
      begin
        val  = gpio_latch[d];
        want = 1'b1;
        od   = ~port_output_mode_i[d];
        if (asg_vld_q[d])
        begin
          val  = periph_out_i[slot];
          want = periph_drive_i[slot];
          // (RULE10) Two-wire bus pins always open-drain
          if (sel_smb_i && (slot == `PXB_SLOT_SDA || slot == `PXB_SLOT_SCL))
            od = 1'b1;
        end
      end

      assign pin_out_d[d] = val;
      // (RULE9) No drive while crossbar disabled
      // Open-drain only pulls low; high is left to the pull-up
      assign pin_oe_n_d[d] = ~(crossbar_enable_bit_i & want & (~od | ~val));
    end
  endgenerate

  // Unrouted slots idle high so their inputs look inactive
  genvar g;
  generate
    for (g = 0; g < `PXB_NSLOT; g = g + 1)
    begin : g_slot
      integer j;
      reg     lvl;

      // Slots never share a pin, so one match at most
      always @*
      begin
        lvl = 1'b1;
        for (j = 0; j < `PXB_NPIN; j = j + 1)
          if (asg_vld_q[j] && asg_slot_q[j*`PXB_SLOT_W +: `PXB_SLOT_W] == g)
            lvl = pin_sync_q[j];
      end

      assign periph_in_d[g] = lvl;
    end
  endgenerate

  // Outputs straight from flops so pins never glitch
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_out_q   <= 15'h0000;
      pin_oe_n_q  <= 15'h7fff;
      periph_in_q <= 24'hffffff;
    end
    else
    begin
      pin_out_q   <= pin_out_d;
      pin_oe_n_q  <= pin_oe_n_d;
      periph_in_q <= periph_in_d;
    end
  end

endmodule

// File: test/pxb_crossbar_asserts.sv
`timescale 1ns/1ps
module pxb_crossbar_asserts
(
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire [7:0]  sfr_addr_i,
  input wire        sfr_rd_i,
  input wire [7:0]  sfr_rdata_o,
  input wire        crossbar_enable_bit_i,
  input wire        sel_uart_i,
  input wire        sel_second_serial_peripheral_i,
  input wire        sel_first_serial_peripheral_i,
  input wire        sel_smb_i,
  input wire [7:0]  port0_skip_mask_i,
  input wire [23:0] periph_out_i,
  input wire [23:0] periph_drive_i,
  input wire [23:0] periph_in_o,
  input wire [14:0] pin_in_i,
  input wire [14:0] pin_out_o,
  input wire [14:0] pin_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  drv_gate_a: assert property (!crossbar_enable_bit_i [*3] |-> &pin_oe_n_o)
    else $error("driver on while crossbar off");
  uart_tx_a: assert property ((sel_uart_i && crossbar_enable_bit_i && periph_drive_i[0]
    && !periph_out_i[0]) [*3] |-> !pin_oe_n_o[4] && !pin_out_o[4]) else $error("tx pin wrong");
  uart_rx_a: assert property (sel_uart_i [*6] |-> periph_in_o[1] == $past(pin_in_i[5], 3))
    else $error("rx pin wrong");
  second_serial_peripheral_in_a: assert property (sel_second_serial_peripheral_i [*6] |-> periph_in_o[3] == $past(pin_in_i[9], 3))
    else $error("second serial input wrong");
  idle_in_a: assert property (!sel_uart_i [*3] |-> periph_in_o[1])
    else $error("unselected input not high");
  sda_od_a: assert property ((sel_smb_i && !sel_first_serial_peripheral_i && !port0_skip_mask_i[0]) [*3]
    |-> pin_oe_n_o[0] || !pin_out_o[0]) else $error("data pin driven high");
  rd_top_a: assert property (sfr_rd_i |=> !sfr_rdata_o[7])
    else $error("bit 7 reads one");
  p1_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'h90 && !$past(rst_i, 3)
    |=> sfr_rdata_o[6:0] == $past(pin_in_i[14:8], 3)) else $error("port read not pin state");
endmodule
bind pxb_priority_pin_crossbar pxb_crossbar_asserts pxb_crossbar_asserts_inst (.*);

// File: test/pxb_pin_model.sv
`timescale 1ns/1ps
module pxb_pin_model
(
  input  wire logic [14:0] pin_out_i,
  input  wire logic [14:0] pin_oe_n_i,
  input  wire logic [14:0] ext_drive_i,
  output logic      [14:0] pin_o
);
  // released pins show the outside level
  assign pin_o = (pin_oe_n_i & ext_drive_i) | (~pin_oe_n_i & pin_out_i);
endmodule

// File: test/tb_pxb_priority_pin_crossbar.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t mismatch", $time); end end
module tb_pxb_priority_pin_crossbar;
  logic        clk_sys_i, rst_i, sfr_wr_i, sfr_rd_i, crossbar_enable_bit_i, sel_uart_i, sel_second_serial_peripheral_i;
  logic        sel_first_serial_peripheral_i, sel_smb_i, sel_cp0_i, sel_cp1_i, sel_sysclk_i, sel_eci_i, sel_t0_i, sel_t1_i;
  logic [1:0]  slave_select_mode_field_i;
  logic [2:0]  sel_cex_cnt_i;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, port0_skip_mask_i, port0_latch_i;
  logic [14:0] port_output_mode_i, pin_in_i, pin_out_o, pin_oe_n_o, ext;
  logic [23:0] periph_out_i, periph_drive_i, periph_in_o;
  int          bad_count, samples_checked;
  pxb_priority_pin_crossbar pxb_priority_pin_crossbar_inst (.*);
  pxb_pin_model pxb_pin_model_inst (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .ext_drive_i(ext), .pin_o(pin_in_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    step(1);
    sfr_wr_i = 1'b0;
    step(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    step(1);
    sfr_rd_i = 1'b0;
    `CHK(sfr_rdata_o, e)
    step(1);
  endtask
  // Pin 15 means unrouted: the slot must idle high
  task pm(input int s, input int p);
    ext = (p > 14) ? 15'h0000 : ~(15'h0001 << p);
    step(6);
    `CHK(periph_in_o[s], 1'(p > 14))
  endtask
  task t_regs;
    ext = 15'h2a55;
    step(4);
    rd(8'h90, 8'h2a);
    rd(8'hd5, 8'h00);
    wr(8'hd5, 8'hff);
    rd(8'hd5, 8'h7f);
    rd(8'h91, 8'h00);
    wr(8'hd5, 8'h00);
  endtask
  task t_route;
    crossbar_enable_bit_i = 1'b1;
    // fixed pins of both serial ports left unskipped
    port0_skip_mask_i = 8'h0c;
    {sel_uart_i, sel_second_serial_peripheral_i, sel_first_serial_peripheral_i, sel_smb_i} = 4'hf;
    pm(1, 5);
    pm(3, 9);
    pm(7, 1);
    pm(9, 15);
    pm(11, 12);
    for (int m = 1; m < 4; m++)
    begin
      slave_select_mode_field_i = m[1:0];
      pm(9, 7);
    end
    pm(11, 13);
    wr(8'hd5, 8'h10);
    pm(11, 14);
    wr(8'hd5, 8'h00);
    {sel_uart_i, sel_second_serial_peripheral_i, sel_first_serial_peripheral_i, sel_smb_i} = 4'h0;
  endtask
  task t_smb;
    port0_skip_mask_i = 8'h00;
    port_output_mode_i = 15'h7fff;
    {sel_uart_i, sel_second_serial_peripheral_i, sel_smb_i} = 3'h7;
    periph_out_i = 24'h000404;
    periph_drive_i = 24'h000405;
    step(3);
    `CHK(pin_oe_n_o[0], 1'b1)
    `CHK(pin_oe_n_o[4], 1'b0)
    `CHK(pin_out_o[8], 1'b1)
    periph_out_i = 24'h000004;
    step(2);
    `CHK({pin_oe_n_o[0], pin_out_o[0]}, 2'b00)
    {sel_uart_i, sel_second_serial_peripheral_i, sel_smb_i} = 3'h0;
    periph_drive_i = 24'h000000;
  endtask
  task t_gpio;
    port0_latch_i = 8'ha5;
    step(3);
    `CHK(pin_out_o, 15'h7fa5)
    `CHK(pin_oe_n_o, 15'h0000)
    wr(8'h90, 8'h85);
    step(3);
    `CHK(pin_out_o[14:8], 7'h05)
    rd(8'h90, 8'h05);
    crossbar_enable_bit_i = 1'b0;
    step(3);
    `CHK(pin_oe_n_o, 15'h7fff)
  endtask
  task t_tail;
    {sel_cp0_i, sel_cp1_i, sel_sysclk_i, sel_eci_i, sel_t0_i, sel_t1_i} = 6'h3f;
    sel_cex_cnt_i = 3'h6;
    pm(23, 11);
    pm(20, 8);
    sel_cex_cnt_i = 3'h2;
    pm(17, 15);
    pm(23, 7);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    {sfr_wr_i, sfr_rd_i, crossbar_enable_bit_i, sel_uart_i, sel_second_serial_peripheral_i, sel_first_serial_peripheral_i, sel_smb_i} = '0;
    {sel_cp0_i, sel_cp1_i, sel_sysclk_i, sel_eci_i, sel_t0_i, sel_t1_i, sel_cex_cnt_i} = '0;
    {slave_select_mode_field_i, sfr_addr_i, sfr_wdata_i, port0_skip_mask_i} = '0;
    {port_output_mode_i, periph_out_i, periph_drive_i} = '0;
    port0_latch_i = 8'hff;
    ext = 15'h7fff;
    rst_i = 1'b1;
    step(10);
    rst_i = 1'b0;
    t_regs;
    t_route;
    t_smb;
    t_gpio;
    t_tail;
    report_and_stop;
  end
endmodule
